// file: design/shs_defs.svh
// register offsets, field positions, reset values and stream constants
`ifndef SHS_DEFS_SVH
`define SHS_DEFS_SVH

`define SHS_REG_CTRL 5'h00
`define SHS_REG_EMB_LEN 5'h04
`define SHS_REG_STATUS 5'h08
`define SHS_REG_PARITY 5'h0c
`define SHS_REG_MB_COUNT 5'h10

`define SHS_CTRL_EN_BIT 0
`define SHS_CTRL_MODE_LSB 4
`define SHS_CTRL_MODE_MSB 5
`define SHS_EMB_LEN_RST 8'h01

`define SHS_STAT_BLK_LSB 0
`define SHS_STAT_MB_LSB 8
`define SHS_STAT_MODE_LSB 16
`define SHS_STAT_RUN_BIT 24

`define SHS_CRC_POLY_HEX 12'h987
`define SHS_FEC_TAPS 26'h0220211
`define SHS_CRC_W 12
`define SHS_FEC_W 26
`define SHS_BLOCK_BITS 64
`define SHS_BLOCKS_PER_MB 32
`define SHS_LAST_BLOCK 5'h1f

`define SHS_CRC_PILOT_ONES 32'h00a88888
`define SHS_END_OF_EXTENDED_MULTIBLOCK_FLAG_POS 22
`define SHS_EOMB_LSB 27
`define SHS_EOMB_PATTERN 5'h10
`define SHS_FEC_HI_LAST 21
`define SHS_FEC_LO_FIRST 23
`define SHS_HDR_ONE 2'h1
`define SHS_HDR_ZERO 2'h2

`endif

// file: design/shs_pkg.sv
// types shared by the sync header stream transmitter
package shs_pkg;
  typedef enum logic [1:0] {
    SH_MODE_CRC12 = 2'h0,
    SH_MODE_FEC = 2'h2
  } sh_mode_type;
  typedef logic [25:0] fec_word_type;
  typedef logic [11:0] crc_word_type;
endpackage

// file: design/shs_parity_step.sv
// one parallel step of a serial parity shift register, msb first
`timescale 1ns/1ps
module shs_parity_step #(
  parameter int W = 12,
  parameter logic [W-1:0] TAPS = '0,
  parameter int DW = 64
) (
  input wire logic [W-1:0] state_in,
  input wire logic [DW-1:0] data_in,
  output logic [W-1:0] state_out
);
  // unrolled bit loop; msb of data is the first serialized bit
  always_comb begin
    logic [W-1:0] s;
    logic fb;
    s = state_in;
    fb = 1'b0;
    for (int i = DW - 1; i >= 0; i--) begin
      fb = data_in[i] ^ s[W-1];
      s = {s[W-2:0], 1'b0} ^ (fb ? TAPS : '0);
    end
    state_out = s;
  end
endmodule

// file: design/shs_avalon_regs.sv
// avalon-mm register slave with one wait state per access
`timescale 1ns/1ps
`include "shs_defs.svh"
module shs_avalon_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic link_enable,
  output shs_pkg::sh_mode_type mode_select,
  output logic [7:0] emb_len,
  input wire logic [31:0] status_word,
  input wire logic [25:0] parity_word,
  input wire logic [31:0] mb_count
);
  import shs_pkg::*;

  logic take;
  logic [1:0] wmode;

  // access completes at the edge where waitrequest is low
  assign take = (read | write) & ~waitrequest;
  assign wmode = writedata[`SHS_CTRL_MODE_MSB:`SHS_CTRL_MODE_LSB];

  // one wait cycle, then a single cycle with waitrequest low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      waitrequest <= 1'b1;
    end else if ((read | write) & waitrequest) begin
      waitrequest <= 1'b0;
    end else begin
      waitrequest <= 1'b1;
    end
  end

  // control register; only the two offered mode codes are accepted
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link_enable <= 1'b0;
      mode_select <= SH_MODE_CRC12;
      emb_len <= `SHS_EMB_LEN_RST;
    end else if (take & write) begin
      if (address == `SHS_REG_CTRL && byteenable[0]) begin
        link_enable <= writedata[`SHS_CTRL_EN_BIT];
        if (wmode == SH_MODE_CRC12) begin
          mode_select <= SH_MODE_CRC12;
        end else if (wmode == SH_MODE_FEC) begin
          mode_select <= SH_MODE_FEC;
        end
      end
      if (address == `SHS_REG_EMB_LEN && byteenable[0]) begin
        emb_len <= writedata[7:0];
      end
    end
  end

  // read data is loaded together with the drop of waitrequest
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      readdata <= 32'h0;
    end else if (read & waitrequest) begin
      case (address)
        `SHS_REG_CTRL: readdata <= {26'h0, mode_select, 3'h0, link_enable};
        `SHS_REG_EMB_LEN: readdata <= {24'h0, emb_len};
        `SHS_REG_STATUS: readdata <= status_word;
        `SHS_REG_PARITY: readdata <= {6'h0, parity_word};
        `SHS_REG_MB_COUNT: readdata <= mb_count;
        default: readdata <= 32'h0;
      endcase
    end
  end
endmodule

// file: design/sync_header_stream_crc_fec.sv
// 64b/66b transmit sync header stream with crc-12 or fec parity
`timescale 1ns/1ps
`include "shs_defs.svh"
module sync_header_stream_crc_fec #(
  parameter int MB_CNT_W = 8
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  // avalon register bus, one wait state per access
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // scrambled blocks in; no ready, so the source can never be stalled
  input wire logic IN_VALID,
  input wire logic [63:0] IN_DATA,
  // coded blocks out, one cycle behind the input
  output logic OUT_VALID,
  output logic [1:0] OUT_HEADER,
  output logic [63:0] OUT_DATA,
  output logic OUT_MB_END,
  output logic OUT_EMB_END
);
  import shs_pkg::*;

  // the hex form drops the +1 term and keeps x^12..x^1 in bits 11..0;
  // the serial divider needs x^11..x^0, so shift one up and add the 1
  localparam logic [11:0] CRC_NAME = `SHS_CRC_POLY_HEX;
  localparam logic [11:0] CRC_TAPS = {CRC_NAME[10:0], 1'b1};

  // configuration from the register slave
  // registered in the slave, so safe to use on this clock directly
  logic link_enable;
  sh_mode_type mode_select;
  logic [7:0] emb_len;

  // framing state
  logic [4:0] blk_q;
  logic [MB_CNT_W-1:0] mb_q;
  logic [31:0] mb_total_q;
  sh_mode_type act_mode_q;
  logic [31:0] shs_q;

  // parity state
  // state words run inside a multiblock, parity words hold the result
  crc_word_type crc_state_q;
  fec_word_type fec_state_q;
  crc_word_type crc_parity_q;
  fec_word_type fec_parity_q;
  crc_word_type crc_seed;
  fec_word_type fec_seed;
  crc_word_type crc_next;
  fec_word_type fec_next;

  // per-block decisions
  // all combinational, evaluated on the block presented at the input
  logic step;
  logic first_blk;
  logic last_blk;
  logic last_mb;
  logic [MB_CNT_W-1:0] mb_wrap;
  sh_mode_type mode_now;
  logic [31:0] shs_now;
  logic hdr_bit;
  logic [31:0] status_word;
  logic [25:0] parity_word;

  // software view: enable, mode, extended length and read-only counters
  shs_avalon_regs u_regs (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .address(AVS_ADDRESS),
    .read(AVS_READ),
    .write(AVS_WRITE),
    .writedata(AVS_WRITEDATA),
    .byteenable(AVS_BYTEENABLE),
    .readdata(AVS_READDATA),
    .waitrequest(AVS_WAITREQUEST),
    .link_enable(link_enable),
    .mode_select(mode_select),
    .emb_len(emb_len),
    .status_word(status_word),
    .parity_word(parity_word),
    .mb_count(mb_total_q)
  );

  // builds the 32-bit stream for one multiblock
  // called only at block zero; the result is held in shs_q so that a
  // parity update at block 31 cannot disturb the stream being sent
  // fec and crc share positions 0-26, end bits are common, pilot ones are crc only
  // a fresh stream per multiblock keeps no state from the one before
  function automatic logic [31:0] build_stream(
    input sh_mode_type mode,
    input crc_word_type crc,
    input fec_word_type fec,
    input logic end_of_extended_multiblock_flag
  );
    logic [31:0] s;
    s = 32'h0;
    if (mode == SH_MODE_FEC) begin
      // parity fills 0-21 and 23-26, jumping over the flag at 22
      for (int p = 0; p <= `SHS_FEC_HI_LAST; p++) begin
        s[p] = fec[25-p];
      end
      for (int p = 0; p < 4; p++) begin
        s[`SHS_FEC_LO_FIRST+p] = fec[3-p];
      end
    end else begin
      // command positions stay zero; only crc and pilot ones are set
      // a one every fourth position keeps 00001 out of the crc field
      for (int g = 0; g < 4; g++) begin
        for (int k = 0; k < 3; k++) begin
          s[4*g+k] = crc[11-3*g-k];
        end
      end
      s = s | `SHS_CRC_PILOT_ONES;
    end
    // end of multiblock and extended flag are common to both formats
    s[`SHS_END_OF_EXTENDED_MULTIBLOCK_FLAG_POS] = end_of_extended_multiblock_flag;
    // pattern bit 4 lands on position 31, the last header sent
    s[`SHS_EOMB_LSB+4:`SHS_EOMB_LSB] = `SHS_EOMB_PATTERN;
    return s;
  endfunction

  // a block is coded only while the link is enabled
  // input blocks while disabled are dropped; none is queued for later
  assign step = IN_VALID & link_enable;
  assign first_blk = (blk_q == 5'h0);
  assign last_blk = (blk_q == `SHS_LAST_BLOCK);
  // a length of zero is treated as one multiblock per extended one
  // (otherwise a zero would wrap to all ones, the longest extended multiblock)
  assign mb_wrap = (emb_len == 8'h0) ? '0 :
    MB_CNT_W'(emb_len - 8'h1);
  assign last_mb = (mb_q >= mb_wrap);

  // mode is sampled at the first block so a multiblock never mixes formats
  // a mode write in mid-multiblock waits for the next boundary
  assign mode_now = first_blk ? mode_select : act_mode_q;

  // the stream of a multiblock is fixed at its first block
  // block k sends stream position k as its header
  assign shs_now = first_blk ?
    build_stream(mode_now, crc_parity_q, fec_parity_q, last_mb) : shs_q;
  assign hdr_bit = shs_now[blk_q];

  // generators restart from zero at block zero
  // seeding here saves a clear cycle between multiblocks
  assign crc_seed = first_blk ? '0 : crc_state_q;
  assign fec_seed = first_blk ? '0 : fec_state_q;

  // headers never enter the generators, only the 64 payload bits
  // each instance unrolls 64 serial shifts into one step per block;
  // the deep xor tree is the price for taking a block every cycle
  // at the word clock instead of running a bit-rate clock
  // both run always, so a mode change needs no warm-up multiblock
  shs_parity_step #(
    .W(`SHS_CRC_W),
    .TAPS(CRC_TAPS),
    .DW(`SHS_BLOCK_BITS)
  ) u_crc (
    .state_in(crc_seed),
    .data_in(IN_DATA),
    .state_out(crc_next)
  );

  shs_parity_step #(
    .W(`SHS_FEC_W),
    .TAPS(`SHS_FEC_TAPS),
    .DW(`SHS_BLOCK_BITS)
  ) u_fec (
    .state_in(fec_seed),
    .data_in(IN_DATA),
    .state_out(fec_next)
  );

  // block and multiblock counters; no alignment sequence precedes data
  // disabling the link restarts framing at block zero of multiblock zero
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      blk_q <= 5'h0;
      mb_q <= '0;
    end else if (!link_enable) begin
      blk_q <= 5'h0;
      mb_q <= '0;
    end else if (step) begin
      blk_q <= blk_q + 5'h1;
      if (last_blk) begin
        mb_q <= last_mb ? '0 : mb_q + 1'b1;
      end
    end
  end

  // count of multiblocks sent since reset, for software
  // wraps silently; software reads it as a free-running tally
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      mb_total_q <= 32'h0;
    end else if (step && last_blk) begin
      mb_total_q <= mb_total_q + 32'h1;
    end
  end

  // latched mode and stream for the rest of the multiblock
  // the stream register feeds hdr_bit for blocks 1 to 31
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      act_mode_q <= SH_MODE_CRC12;
      shs_q <= 32'h0;
    end else if (step && first_blk) begin
      act_mode_q <= mode_select;
      shs_q <= shs_now;
    end
  end

  // running generator state
  // state while idle is kept; the seed reloads it at the next block zero
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      crc_state_q <= '0;
      fec_state_q <= '0;
    end else if (step) begin
      crc_state_q <= crc_next;
      fec_state_q <= fec_next;
    end
  end

  // parity of the finished multiblock, carried by the following one;
  // cleared while disabled so a restarted link sends zero parity first
  // (a stale word would fail the far end's first comparison)
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      crc_parity_q <= '0;
      fec_parity_q <= '0;
    end else if (!link_enable) begin
      crc_parity_q <= '0;
      fec_parity_q <= '0;
    end else if (step && last_blk) begin
      crc_parity_q <= crc_next;
      fec_parity_q <= fec_next;
    end
  end

  // output block: header pair in front of the unchanged payload
  // data is held between blocks; only the valid pulse marks a new one
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      OUT_VALID <= 1'b0;
      OUT_HEADER <= `SHS_HDR_ZERO;
      OUT_DATA <= 64'h0;
    end else begin
      OUT_VALID <= step;
      if (step) begin
        OUT_HEADER <= hdr_bit ? `SHS_HDR_ONE : `SHS_HDR_ZERO;
        OUT_DATA <= IN_DATA;
      end
    end
  end

  // boundary markers travel with the last block of each multiblock
  // downstream framing can use these instead of decoding the stream
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      OUT_MB_END <= 1'b0;
      OUT_EMB_END <= 1'b0;
    end else begin
      OUT_MB_END <= step & last_blk;
      OUT_EMB_END <= step & last_blk & last_mb;
    end
  end

  // status word and the parity word of the active format
  // the multiblock index is cut to eight bits for the status field
  // the crc word is zero-extended so both formats share one register
  assign status_word = {7'h0, link_enable, 6'h0, act_mode_q,
    8'(mb_q), 3'h0, blk_q};
  assign parity_word = (act_mode_q == SH_MODE_FEC) ? fec_parity_q :
    {14'h0, crc_parity_q};
endmodule

// file: dv/shs_rx_model.sv
// far-end receiver model: stream capture and parity syndrome
`timescale 1ns/1ps
module shs_rx_model #(
  parameter int BUFFER_RELEASE_DELAY = 0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic fec_mode,
  input wire logic valid,
  input wire logic [1:0] hdr,
  input wire logic [63:0] data,
  output logic [31:0] sh_q,
  output logic [25:0] syndrome,
  output logic mb_lock,
  output logic released
);
  logic [1:0] hits_q;
  logic fill_q;
  logic eomb_seen;
  logic [4:0] cnt_q;
  logic [25:0] own_q;
  logic [25:0] prev_q;
  logic [25:0] old_q;
  logic [25:0] rx_par;
  logic [25:0] step;

  // msb-first serial divider over one 64-bit block
  function automatic logic [25:0] par_step(input logic [25:0] s,
      input logic [63:0] d, input logic f);
    logic fb;
    for (int i = 63; i >= 0; i--) begin
      fb = d[i] ^ (f ? s[25] : s[11]);
      s = f ? s << 1 : (s << 1) & 26'hfff;
      if (fb) s = s ^ (f ? 26'h0220211 : 26'h000030f);
    end
    return s;
  endfunction

  assign step = par_step(own_q, data, fec_mode);
  // frames on a block count alone; a slipped block would go unseen
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 5'h0;
      sh_q <= 32'h0;
      own_q <= 26'h0;
      prev_q <= 26'h0;
      old_q <= 26'h0;
    end else if (valid) begin
      sh_q[cnt_q] <= (hdr == 2'h1);
      cnt_q <= cnt_q + 5'h1;
      own_q <= (cnt_q == 5'h1f) ? 26'h0 : step;
      if (cnt_q == 5'h1f) begin
        prev_q <= step;
        old_q <= prev_q;
      end
    end
  end

  // end pattern of the multiblock now closing; last bit from the pin
  assign eomb_seen = ({sh_q[27], sh_q[28], sh_q[29], sh_q[30],
      hdr == 2'h1} == 5'h01);
  assign mb_lock = hits_q[1];

  // alignment after two end patterns in a row, then buffer and release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hits_q <= 2'h0;
      fill_q <= 1'b0;
      released <= 1'b0;
    end else if (valid) begin
      if (cnt_q == 5'h1f) begin
        if (!eomb_seen) begin
          hits_q <= 2'h0;
        end else if (!hits_q[1]) begin
          hits_q <= hits_q + 2'h1;
        end
        // buffering starts with the block after an extended end
        if (mb_lock && sh_q[22]) fill_q <= 1'b1;
      end
      // release point: programmed block offset from the extended start
      if (fill_q && cnt_q == 5'(BUFFER_RELEASE_DELAY)) begin
        released <= 1'b1;
      end
    end
  end

  // received parity against own parity of the multiblock before;
  // known only once the next multiblock has ended, 63 blocks on
  always_comb begin
    rx_par = 26'h0;
    for (int i = 0; i < 22; i++) rx_par[25-i] = sh_q[i];
    for (int i = 0; i < 4; i++) rx_par[3-i] = sh_q[23+i];
    if (!fec_mode) begin
      rx_par = 26'h0;
      for (int g = 0; g < 4; g++) begin
        for (int j = 0; j < 3; j++) rx_par[11-3*g-j] = sh_q[4*g+j];
      end
    end
    syndrome = rx_par ^ old_q;
  end
endmodule

// file: dv/sync_header_stream_crc_fec_chk.sv
// stream framing checker bound to the transmitter top
`timescale 1ns/1ps
module shs_stream_chk #(
  parameter int MB_CNT_W = 8
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic IN_VALID,
  input wire logic [63:0] IN_DATA,
  input wire logic OUT_VALID,
  input wire logic [1:0] OUT_HEADER,
  input wire logic [63:0] OUT_DATA,
  input wire logic OUT_MB_END,
  input wire logic OUT_EMB_END
);
  logic [4:0] blk_q;
  logic [4:0] hist_q;
  logic e22_q;

  // block position and the last five stream bits seen
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      blk_q <= 5'h0;
      hist_q <= 5'h0;
      e22_q <= 1'b0;
    end else if (OUT_VALID) begin
      blk_q <= blk_q + 5'h1;
      hist_q <= {hist_q[3:0], OUT_HEADER == 2'h1};
      if (blk_q == 5'h16) e22_q <= (OUT_HEADER == 2'h1);
    end
  end

  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  chk_valid_delay: assert property (OUT_VALID |-> $past(IN_VALID))
    else $error("output block without input block");
  chk_data_copy: assert property (OUT_VALID |->
    OUT_DATA == $past(IN_DATA))
    else $error("payload changed");
  chk_header_code: assert property (OUT_VALID |->
    OUT_HEADER inside {2'h1, 2'h2})
    else $error("illegal header");
  chk_mb_position: assert property (OUT_VALID |->
    OUT_MB_END == (blk_q == 5'h1f))
    else $error("multiblock end misplaced");
  chk_end_pattern: assert property (OUT_MB_END |=> hist_q == 5'h01)
    else $error("end pattern wrong");
  chk_mb_gap: assert property (OUT_MB_END |=> !OUT_MB_END [*8])
    else $error("multiblock ends too close");
  chk_emb_flag: assert property (OUT_MB_END |-> OUT_EMB_END == e22_q)
    else $error("flag and extended end disagree");
  chk_emb_in_mb: assert property (OUT_EMB_END |->
    OUT_MB_END && OUT_VALID)
    else $error("extended end off boundary");
endmodule

bind sync_header_stream_crc_fec shs_stream_chk #(.MB_CNT_W(MB_CNT_W)) u_chk (
  .REF_CLK(REF_CLK), .RST_N(RST_N), .IN_VALID(IN_VALID), .IN_DATA(IN_DATA),
  .OUT_VALID(OUT_VALID), .OUT_HEADER(OUT_HEADER), .OUT_DATA(OUT_DATA),
  .OUT_MB_END(OUT_MB_END), .OUT_EMB_END(OUT_EMB_END));

// file: dv/sync_header_stream_crc_fec_test.sv
// self-checking bench: registers, crc and fec stream layouts
`timescale 1ns/1ps
module sync_header_stream_crc_fec_test;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] addr = 5'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic wait_rq;
  logic in_valid = 1'b0;
  logic [63:0] in_data = 64'h0;
  logic [63:0] out_data;
  logic [1:0] out_hdr;
  logic out_valid;
  logic fec_mode = 1'b0;
  logic [31:0] sh;
  logic [25:0] syn;
  logic lock;
  logic rel;
  logic [25:0] prev_par = 26'h0;
  logic [31:0] q;
  int seq = 0;
  int n_mismatch = 0;
  int cmp_count = 0;

  always #25 ref_clk = ~ref_clk;

  sync_header_stream_crc_fec #(.MB_CNT_W(8)) u_dut (.REF_CLK(ref_clk),
    .RST_N(rst_n), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wait_rq), .IN_VALID(in_valid), .IN_DATA(in_data),
    .OUT_VALID(out_valid), .OUT_HEADER(out_hdr), .OUT_DATA(out_data),
    .OUT_MB_END(), .OUT_EMB_END());

  shs_rx_model u_rx (.clk(ref_clk), .rst_n(rst_n), .fec_mode(fec_mode),
    .valid(out_valid), .hdr(out_hdr), .data(out_data), .sh_q(sh),
    .syndrome(syn), .mb_lock(lock), .released(rel));

  task automatic check(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [4:0] a,
      input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    // no cycle limit here: only the watchdog ends a hung access
    do begin
      @(posedge ref_clk);
    end while (wait_rq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  // 32 back-to-back blocks, then the whole stream is judged
  task automatic send_mb(input logic end_of_extended_multiblock_flag, input logic syn_chk);
    logic [31:0] e;
    logic [63:0] d;
    logic [25:0] p;
    p = 26'h0;
    for (int k = 0; k < 32; k++) begin
      @(posedge ref_clk);
      seq++;
      d = {seq * 32'h9e3779b9, ~seq};
      in_valid <= 1'b1;
      in_data <= d;
      p = u_rx.par_step(p, d, fec_mode);
    end
    @(posedge ref_clk);
    in_valid <= 1'b0;
    repeat (2) @(posedge ref_clk);
    e = {1'b1, 8'h0, end_of_extended_multiblock_flag, 22'h0};
    if (fec_mode) begin
      for (int i = 0; i < 22; i++) e[i] = prev_par[25-i];
      for (int i = 0; i < 4; i++) e[23+i] = prev_par[3-i];
    end else begin
      e = e | 32'h00a88888;
      for (int g = 0; g < 4; g++)
        for (int j = 0; j < 3; j++) e[4*g+j] = prev_par[11-3*g-j];
    end
    check("stream", e, sh);
    if (syn_chk) check("syndrome", 32'h0, {6'h0, syn});
    if (syn_chk) check("lock", 32'h1, {31'h0, lock});
    prev_par = p;
  endtask

  task automatic test_regs();
    bus(1'b0, 5'h00, 32'h0);
    check("ctrl", 32'h0, q);
    bus(1'b0, 5'h04, 32'h0);
    check("emb_len", 32'h1, q);
    bus(1'b1, 5'h14, 32'hffffffff);
    bus(1'b0, 5'h14, 32'h0);
    check("unmapped", 32'h0, q);
  endtask

  task automatic test_crc();
    bus(1'b1, 5'h04, 32'h2);
    bus(1'b1, 5'h00, 32'h1);
    send_mb(1'b0, 1'b0);
    send_mb(1'b1, 1'b1);
    send_mb(1'b0, 1'b1);
    bus(1'b1, 5'h00, 32'h11);
    bus(1'b0, 5'h00, 32'h0);
    check("ctrl", 32'h1, q);
    check("released", 32'h0, {31'h0, rel});
    bus(1'b1, 5'h00, 32'h0);
  endtask

  task automatic test_fec();
    fec_mode = 1'b1;
    prev_par = 26'h0;
    bus(1'b1, 5'h04, 32'h1);
    bus(1'b1, 5'h00, 32'h21);
    send_mb(1'b1, 1'b0);
    send_mb(1'b1, 1'b1);
    send_mb(1'b1, 1'b1);
    check("released", 32'h1, {31'h0, rel});
    bus(1'b0, 5'h10, 32'h0);
    check("mb_count", 32'h6, q);
    bus(1'b0, 5'h0c, 32'h0);
    check("parity", {6'h0, prev_par}, q);
    bus(1'b0, 5'h08, 32'h0);
    check("status", 32'h01020000, q);
  endtask

  task automatic print_verdict();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    test_regs();
    test_crc();
    test_fec();
    print_verdict();
  end

  // watchdog, well past the few hundred cycles the run needs
  initial begin
    repeat (4000) @(posedge ref_clk);
    n_mismatch++;
    print_verdict();
  end
endmodule
